// ---- motor_pwm_output_fault_update_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module motor_pwm_output_fault_update_test;
    import mpofu_pkg::*;
    // ****
    // signals
    // ****
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic f0 = 1'h0, f1 = 1'h0, edge_al = 1'h1;
    logic [3:0] adc = 4'h0, p_raw = 4'hF, n_raw = 4'h0, n_ind = 4'hF;
    logic [15:0] cv = 16'h0005, start_v = 16'h0010;
    wire logic awready, wready, bvalid, arready, rvalid, zc, st, sl, oe;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [3:0] p_out, n_out, adc_req;
    int fails = 0, n_compared = 0, n_loads = 0, overlap;
    logic [31:0] regs [6] = '{MPOFU_ADDR_FAULT_FLAGS, MPOFU_ADDR_DMA_ENABLE, MPOFU_ADDR_PUSH_PULL,
        MPOFU_ADDR_PAIR_A, MPOFU_ADDR_PAIR_B, MPOFU_ADDR_SCHEDULE};
    logic [7:0] cfgs [6] = '{8'h00, 8'h40, 8'h1C, 8'h02, 8'h42, 8'h80};
    logic [3:0] exp_p [6] = '{4'hF, 4'h0, 4'h0, 4'h0, 4'hF, 4'hF};
    logic [3:0] exp_n [6] = '{4'h0, 4'hF, 4'hF, 4'h0, 4'hF, 4'hF};
    mpofu_top #(.CNT_W(16)) u_dut (.sys_clk(clk), .sys_rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .counter_value(cv), .counter_start_value(start_v), .edge_aligned_mode(edge_al),
        .pwm_p_raw(p_raw), .pwm_n_raw(n_raw), .pwm_n_indep(n_ind),
        .fault_input_zero(f0), .fault_input_one(f1), .adc_trigger_event(adc),
        .pwm_p_out(p_out), .pwm_n_out(n_out), .zero_cross_dma_req(zc), .start_event_dma_req(st),
        .adc_trigger_dma_req(adc_req), .shadow_load(sl), .output_enable_signal(oe));
    mpofu_gate_model u_gate (.clk(clk), .p_gate(p_out), .n_gate(n_out), .overlap_cycles(overlap));
    initial forever #50 clk = ~clk;
    always @(posedge clk) n_loads <= n_loads + (sl === 1'h1);
    // ****
    // tasks
    // ****
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : ck
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do @(posedge clk); while ((awready & wready) !== 1'h1);
        awvalid <= 1'h0;
        wvalid <= 1'h0;
        while (bvalid !== 1'h1) @(posedge clk);
        bready <= 1'h0;
        ck({30'h0, bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        while (rvalid !== 1'h1) @(posedge clk);
        rready <= 1'h0;
        ck(rdata, e);
        ck({30'h0, rresp}, {30'h0, er});
    endtask : rd
    // one event cycle; results registered at the closing edge are settled on return
    task automatic stim(input logic [15:0] c, input logic a, input logic b, input logic [3:0] t);
        @(posedge clk);
        cv <= c;
        f0 <= a;
        f1 <= b;
        adc <= t;
        @(posedge clk);
        cv <= 16'h0005;
        f0 <= 1'h0;
        f1 <= 1'h0;
        adc <= 4'h0;
        #1;
    endtask : stim
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    initial
    begin
        #2000000;
        fails++;
        final_report();
    end
    // ****
    // tests
    // ****
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        foreach (regs[i]) rd(regs[i], 32'h0, MPOFU_RESP_OKAY);
        rd(32'h40011C5C, 32'h0, MPOFU_RESP_SLVERR);
        wr(32'h40011C5C, 32'hFFFFFFFF, MPOFU_RESP_SLVERR);
        wr(MPOFU_ADDR_DMA_ENABLE, 32'h3F, MPOFU_RESP_OKAY);
        rd(MPOFU_ADDR_DMA_ENABLE, 32'h0, MPOFU_RESP_OKAY);
        wr(MPOFU_ADDR_PROTECT, 32'hDEAD, MPOFU_RESP_OKAY);
        rd(MPOFU_ADDR_PROTECT, 32'hDEAD, MPOFU_RESP_OKAY);
        wr(MPOFU_ADDR_DMA_ENABLE, 32'hFFFFFFFF, MPOFU_RESP_OKAY);
        rd(MPOFU_ADDR_DMA_ENABLE, 32'h3F, MPOFU_RESP_OKAY);
        wr(MPOFU_ADDR_DMA_ENABLE, 32'h25, MPOFU_RESP_OKAY);
        stim(16'h0000, 1'h0, 1'h0, 4'hF);
        ck({26'h0, zc, st, adc_req}, 32'h25);
        stim(16'h0010, 1'h0, 1'h0, 4'h0);
        ck({26'h0, zc, st, adc_req}, 32'h0);
        wr(MPOFU_ADDR_DMA_ENABLE, 32'h1A, MPOFU_RESP_OKAY);
        stim(16'h0000, 1'h0, 1'h0, 4'hF);
        ck({26'h0, zc, st, adc_req}, 32'hA);
        stim(16'h0010, 1'h0, 1'h0, 4'h0);
        ck({26'h0, zc, st, adc_req}, 32'h10);
        wr(MPOFU_ADDR_OUT_CTRL, 32'h1, MPOFU_RESP_OKAY);
        for (int i = 0; i < 6; i++)
        begin
            wr(MPOFU_ADDR_PAIR_A, {16'h0, cfgs[i], cfgs[i]}, MPOFU_RESP_OKAY);
            wr(MPOFU_ADDR_PAIR_B, {16'h0, cfgs[i], cfgs[i]}, MPOFU_RESP_OKAY);
            rd(MPOFU_ADDR_PAIR_B, {16'h0, cfgs[i], cfgs[i]}, MPOFU_RESP_OKAY);
            ck({24'h0, p_out, n_out}, {24'h0, exp_p[i], exp_n[i]});
        end
        ck({31'h0, overlap != 0}, 32'h1);
        wr(MPOFU_ADDR_FAULT_FLAGS, 32'h0F, MPOFU_RESP_OKAY);
        rd(MPOFU_ADDR_FAULT_FLAGS, 32'h0F, MPOFU_RESP_OKAY);
        wr(MPOFU_ADDR_PAIR_A, 32'h0, MPOFU_RESP_OKAY);
        wr(MPOFU_ADDR_PAIR_B, 32'h0, MPOFU_RESP_OKAY);
        wr(MPOFU_ADDR_FAULT_FLAGS, 32'h0F, MPOFU_RESP_OKAY);
        rd(MPOFU_ADDR_FAULT_FLAGS, 32'h0, MPOFU_RESP_OKAY);
        stim(16'h0005, 1'h0, 1'h1, 4'h0);
        ck({31'h0, oe}, 32'h0);
        @(posedge clk);
        #1;
        ck({24'h0, p_out, n_out}, 32'h0);
        rd(MPOFU_ADDR_FAULT_FLAGS, 32'h20, MPOFU_RESP_OKAY);
        wr(MPOFU_ADDR_FAULT_FLAGS, 32'h0, MPOFU_RESP_OKAY);
        rd(MPOFU_ADDR_FAULT_FLAGS, 32'h20, MPOFU_RESP_OKAY);
        stim(16'h0005, 1'h1, 1'h0, 4'h0);
        rd(MPOFU_ADDR_FAULT_FLAGS, 32'h30, MPOFU_RESP_OKAY);
        wr(MPOFU_ADDR_SCHEDULE, 32'h61, MPOFU_RESP_OKAY);
        stim(16'h0000, 1'h0, 1'h0, 4'h0);
        repeat (2) @(posedge clk);
        ck(n_loads, 32'h0);
        stim(16'h0000, 1'h0, 1'h0, 4'h0);
        ck({31'h0, oe}, 32'h1);
        rd(MPOFU_ADDR_FAULT_FLAGS, 32'h0, MPOFU_RESP_OKAY);
        ck(n_loads, 32'h1);
        ck({24'h0, p_out, n_out}, 32'hF0);
        wr(MPOFU_ADDR_SCHEDULE, 32'h10, MPOFU_RESP_OKAY);
        stim(16'h0000, 1'h0, 1'h0, 4'h0);
        stim(16'h0010, 1'h0, 1'h0, 4'h0);
        repeat (2) @(posedge clk);
        ck(n_loads, 32'h2);
        wr(MPOFU_ADDR_SCHEDULE, 32'h0, MPOFU_RESP_OKAY);
        stim(16'h0000, 1'h0, 1'h0, 4'h0);
        stim(16'h0010, 1'h0, 1'h0, 4'h0);
        wr(MPOFU_ADDR_MANUAL_LOAD, 32'h1, MPOFU_RESP_OKAY);
        repeat (2) @(posedge clk);
        ck(n_loads, 32'h3);
        wr(MPOFU_ADDR_PUSH_PULL, 32'hF, MPOFU_RESP_OKAY);
        rd(MPOFU_ADDR_PUSH_PULL, 32'hF, MPOFU_RESP_OKAY);
        ck({24'h0, p_out, n_out}, 32'h0F);
        stim(16'h0010, 1'h0, 1'h0, 4'h0);
        repeat (2) @(posedge clk);
        ck({24'h0, p_out, n_out}, 32'hF0);
        edge_al <= 1'h0;
        stim(16'h0010, 1'h0, 1'h0, 4'h0);
        repeat (2) @(posedge clk);
        ck({24'h0, p_out, n_out}, 32'hF0);
        stim(16'h0000, 1'h0, 1'h0, 4'h0);
        repeat (2) @(posedge clk);
        ck({24'h0, p_out, n_out}, 32'h0F);
        wr(MPOFU_ADDR_PROTECT, 32'h0, MPOFU_RESP_OKAY);
        wr(MPOFU_ADDR_DMA_ENABLE, 32'h0, MPOFU_RESP_OKAY);
        rd(MPOFU_ADDR_DMA_ENABLE, 32'h1A, MPOFU_RESP_OKAY);
        final_report();
    end
endmodule : motor_pwm_output_fault_update_test
`default_nettype wire

// ---- mpofu_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpofu_checker #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // bus
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // events
    input wire logic [CNT_W-1:0] counter_value,
    input wire logic [CNT_W-1:0] counter_start_value,
    input wire logic fault_input_zero,
    input wire logic fault_input_one,
    input wire logic [3:0] adc_trigger_event,
    // results
    input wire logic zero_cross_dma_req,
    input wire logic start_event_dma_req,
    input wire logic [3:0] adc_trigger_dma_req,
    input wire logic shadow_load,
    input wire logic output_enable_signal
);
    wire logic at_start = (counter_value == counter_start_value);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // awready only rises with both write channels valid
    sequence s_wr_take; s_axi_awready; endsequence
    sequence s_b_stand; s_axi_bvalid && !s_axi_bready; endsequence
    property p_wr_answer; s_wr_take |=> s_axi_bvalid; endproperty
    property p_b_hold; s_b_stand |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    property p_fault_oe; fault_input_zero || fault_input_one |=> !output_enable_signal; endproperty
    property p_zero_dma; zero_cross_dma_req |-> $past(counter_value) == 0 && $past(counter_value, 2) != 0; endproperty
    property p_start_dma; start_event_dma_req |-> $past(at_start) && !$past(at_start, 2); endproperty
    property p_adc_dma; |adc_trigger_dma_req |-> (adc_trigger_dma_req & ~$past(adc_trigger_event)) == 4'h0; endproperty
    property p_oe_rise; $rose(output_enable_signal) |-> shadow_load || s_axi_bvalid; endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write not answered");
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped early");
    a_fault_oe: assert property (p_fault_oe)
        else $error("output enable kept after fault");
    a_zero_dma: assert property (p_zero_dma)
        else $error("zero request without zero event");
    a_start_dma: assert property (p_start_dma)
        else $error("start request without start event");
    a_adc_dma: assert property (p_adc_dma)
        else $error("adc request without trigger");
    a_oe_rise: assert property (p_oe_rise)
        else $error("output enable set without cause");
endmodule : mpofu_checker
bind mpofu_top mpofu_checker #(.CNT_W(CNT_W)) u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .counter_value(counter_value), .counter_start_value(counter_start_value),
    .fault_input_zero(fault_input_zero), .fault_input_one(fault_input_one),
    .adc_trigger_event(adc_trigger_event), .zero_cross_dma_req(zero_cross_dma_req),
    .start_event_dma_req(start_event_dma_req), .adc_trigger_dma_req(adc_trigger_dma_req),
    .shadow_load(shadow_load), .output_enable_signal(output_enable_signal));
`default_nettype wire

// ---- mpofu_gate_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpofu_gate_model (
    // clock
    input wire logic clk,
    // gate inputs
    input wire logic [3:0] p_gate,
    input wire logic [3:0] n_gate,
    // bridge status
    output int overlap_cycles
);
    // a real half bridge would short here; the model only counts such cycles
    initial overlap_cycles = 0;
    always @(posedge clk)
        if ((p_gate & n_gate) != 4'h0)
            overlap_cycles <= overlap_cycles + 1;
endmodule : mpofu_gate_model
`default_nettype wire

// ---- mpofu_pkg.sv ----
`default_nettype none
package mpofu_pkg;
    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [31:0] MPOFU_ADDR_FAULT_FLAGS = 32'h40011C44;
    localparam logic [31:0] MPOFU_ADDR_DMA_ENABLE = 32'h40011C48;
    localparam logic [31:0] MPOFU_ADDR_PUSH_PULL = 32'h40011C4C;
    localparam logic [31:0] MPOFU_ADDR_PAIR_A = 32'h40011C50;
    localparam logic [31:0] MPOFU_ADDR_PAIR_B = 32'h40011C54;
    localparam logic [31:0] MPOFU_ADDR_SCHEDULE = 32'h40011C58;
    localparam logic [31:0] MPOFU_ADDR_OUT_CTRL = 32'h40011C6C;
    localparam logic [31:0] MPOFU_ADDR_MANUAL_LOAD = 32'h40011C70;
    localparam logic [31:0] MPOFU_ADDR_PROTECT = 32'h40011C74;
    // ****************************************
    // field positions and widths
    // ****************************************
    localparam int MPOFU_FAULT_ONE_BIT = 5;
    localparam int MPOFU_FAULT_ZERO_BIT = 4;
    localparam int MPOFU_ZC_DMA_BIT = 5;
    localparam int MPOFU_START_DMA_BIT = 4;
    localparam int MPOFU_CFG_MODE_BIT = 7;
    localparam int MPOFU_CFG_SWAP_BIT = 6;
    localparam int MPOFU_CFG_PVAL_BIT = 5;
    localparam int MPOFU_CFG_NVAL_BIT = 4;
    localparam int MPOFU_CFG_PSRC_BIT = 3;
    localparam int MPOFU_CFG_NSRC_BIT = 2;
    localparam int MPOFU_CFG_PPOL_BIT = 1;
    localparam int MPOFU_CFG_NPOL_BIT = 0;
    localparam int MPOFU_AUTO_CLR_BIT = 6;
    localparam int MPOFU_ZERO_UPD_BIT = 5;
    localparam int MPOFU_START_UPD_BIT = 4;
    localparam int MPOFU_OE_BIT = 0;
    localparam int MPOFU_DEFAULT_LSB = 8;
    localparam int MPOFU_FLAGS_W = 6;
    localparam int MPOFU_DMA_W = 6;
    localparam int MPOFU_PP_W = 4;
    localparam int MPOFU_PAIR_W = 16;
    localparam int MPOFU_SCHED_W = 7;
    localparam int MPOFU_INTV_W = 4;
    localparam int MPOFU_KEY_W = 16;
    // ****************************************
    // reset values and codes
    // ****************************************
    localparam logic [5:0] MPOFU_FLAGS_RESET = 6'h00;
    localparam logic [5:0] MPOFU_DMA_RESET = 6'h00;
    localparam logic [3:0] MPOFU_PP_RESET = 4'h0;
    localparam logic [15:0] MPOFU_PAIR_RESET = 16'h0000;
    localparam logic [6:0] MPOFU_SCHED_RESET = 7'h00;
    localparam logic [7:0] MPOFU_DEFAULT_RESET = 8'h00;
    localparam logic [15:0] MPOFU_KEY_RESET = 16'h0000;
    localparam logic [15:0] MPOFU_UNLOCK_KEY = 16'hDEAD;
    localparam logic [1:0] MPOFU_RESP_OKAY = 2'h0;
    localparam logic [1:0] MPOFU_RESP_SLVERR = 2'h2;
endpackage : mpofu_pkg
`default_nettype wire

// ---- mpofu_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpofu_top #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // axi4-lite slave
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // counter and waveform sources
    input wire logic [CNT_W-1:0] counter_value,
    input wire logic [CNT_W-1:0] counter_start_value,
    input wire logic edge_aligned_mode,
    input wire logic [3:0] pwm_p_raw,
    input wire logic [3:0] pwm_n_raw,
    input wire logic [3:0] pwm_n_indep,
    // fault and trigger events
    input wire logic fault_input_zero,
    input wire logic fault_input_one,
    input wire logic [3:0] adc_trigger_event,
    // gate driver outputs
    output logic [3:0] pwm_p_out,
    output logic [3:0] pwm_n_out,
    // dma, shadow load and output enable
    output logic zero_cross_dma_req,
    output logic start_event_dma_req,
    output logic [3:0] adc_trigger_dma_req,
    output logic shadow_load,
    output logic output_enable_signal
);
    import mpofu_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] mpofu_merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction : mpofu_merge

    // ****************************************
    // registers
    // ****************************************
    logic [5:0] fault_flags_reg;
    logic [5:0] dma_enable_reg;
    logic [3:0] push_pull_reg;
    logic [15:0] pair_a_reg;
    logic [15:0] pair_b_reg;
    logic [6:0] schedule_reg;
    logic [7:0] default_level_reg;
    logic [15:0] protect_key_reg;
    logic oe_reg;
    logic [3:0] upd_cnt_reg;
    logic [CNT_W-1:0] prev_cnt_reg;
    logic pp_phase_reg;
    logic [3:0] p_out_reg;
    logic [3:0] n_out_reg;
    logic shadow_load_reg;
    logic zc_req_reg;
    logic st_req_reg;
    logic [3:0] adc_req_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;

    // ****************************************
    // bus decode
    // ****************************************
    wire wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
    wire rd_fire = s_axi_arvalid & ~rvalid_reg;
    wire unlocked = (protect_key_reg == MPOFU_UNLOCK_KEY);
    wire hit_flags = wr_fire & (s_axi_awaddr == MPOFU_ADDR_FAULT_FLAGS);
    wire hit_dma = wr_fire & unlocked & (s_axi_awaddr == MPOFU_ADDR_DMA_ENABLE);
    wire hit_pp = wr_fire & unlocked & (s_axi_awaddr == MPOFU_ADDR_PUSH_PULL);
    wire hit_pair_a = wr_fire & unlocked & (s_axi_awaddr == MPOFU_ADDR_PAIR_A);
    wire hit_pair_b = wr_fire & unlocked & (s_axi_awaddr == MPOFU_ADDR_PAIR_B);
    wire hit_sched = wr_fire & unlocked & (s_axi_awaddr == MPOFU_ADDR_SCHEDULE);
    wire hit_out = wr_fire & unlocked & (s_axi_awaddr == MPOFU_ADDR_OUT_CTRL);
    wire hit_manual = wr_fire & (s_axi_awaddr == MPOFU_ADDR_MANUAL_LOAD);
    wire hit_protect = wr_fire & (s_axi_awaddr == MPOFU_ADDR_PROTECT);
    wire wr_mapped = (s_axi_awaddr == MPOFU_ADDR_FAULT_FLAGS) | (s_axi_awaddr == MPOFU_ADDR_DMA_ENABLE)
                   | (s_axi_awaddr == MPOFU_ADDR_PUSH_PULL) | (s_axi_awaddr == MPOFU_ADDR_PAIR_A)
                   | (s_axi_awaddr == MPOFU_ADDR_PAIR_B) | (s_axi_awaddr == MPOFU_ADDR_SCHEDULE)
                   | (s_axi_awaddr == MPOFU_ADDR_OUT_CTRL) | (s_axi_awaddr == MPOFU_ADDR_MANUAL_LOAD)
                   | (s_axi_awaddr == MPOFU_ADDR_PROTECT);
    wire [31:0] w_dma = mpofu_merge({26'h0, dma_enable_reg}, s_axi_wdata, s_axi_wstrb);
    wire [31:0] w_pp = mpofu_merge({28'h0, push_pull_reg}, s_axi_wdata, s_axi_wstrb);
    wire [31:0] w_pair_a = mpofu_merge({16'h0, pair_a_reg}, s_axi_wdata, s_axi_wstrb);
    wire [31:0] w_pair_b = mpofu_merge({16'h0, pair_b_reg}, s_axi_wdata, s_axi_wstrb);
    wire [31:0] w_sched = mpofu_merge({25'h0, schedule_reg}, s_axi_wdata, s_axi_wstrb);
    wire [31:0] w_out = mpofu_merge({16'h0, default_level_reg, 7'h00, oe_reg}, s_axi_wdata, s_axi_wstrb);
    wire [31:0] w_key = mpofu_merge({16'h0, protect_key_reg}, s_axi_wdata, s_axi_wstrb);
    // write-1-clear only acts on bytes actually strobed; zeros leave flags alone
    wire [5:0] flag_w1c = hit_flags ? (s_axi_wdata[5:0] & {6{s_axi_wstrb[0]}}) : 6'h00;
    wire manual_load = hit_manual & s_axi_wstrb[0] & s_axi_wdata[0];

    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    assign s_axi_arready = ~rvalid_reg;

    // ****************************************
    // counter events
    // ****************************************
    wire zero_event = (counter_value == '0) & (prev_cnt_reg != '0);
    wire start_event = (counter_value == counter_start_value) & (prev_cnt_reg != counter_start_value);
    wire zero_upd_en = schedule_reg[MPOFU_ZERO_UPD_BIT];
    wire start_upd_en = schedule_reg[MPOFU_START_UPD_BIT];
    wire [3:0] interval = schedule_reg[MPOFU_INTV_W-1:0];
    wire sched_event = (zero_event & zero_upd_en) | (start_event & start_upd_en);
    wire auto_load = sched_event & (upd_cnt_reg == interval);
    wire auto_clear = auto_load & schedule_reg[MPOFU_AUTO_CLR_BIT];
    // centre-aligned pairs alternate on the zero point, edge-aligned on the period start
    wire pp_toggle = edge_aligned_mode ? start_event : zero_event;

    // ****************************************
    // output path per channel
    // ****************************************
    wire [31:0] chan_cfg = {pair_b_reg, pair_a_reg};
    logic [3:0] p_next;
    logic [3:0] n_next;
    logic [3:0] shoot_through;

    for (genvar ch = 0; ch < 4; ch++)
    begin : g_chan
        wire [7:0] cfg = chan_cfg[8*ch +: 8];
        wire n_wave = cfg[MPOFU_CFG_MODE_BIT] ? pwm_n_indep[ch] : pwm_n_raw[ch];
        wire pp_p = pwm_p_raw[ch] & pp_phase_reg;
        wire pp_n = pwm_p_raw[ch] & ~pp_phase_reg;
        wire gen_p = push_pull_reg[ch] ? pp_p : pwm_p_raw[ch];
        wire gen_n = push_pull_reg[ch] ? pp_n : n_wave;
        wire src_p = cfg[MPOFU_CFG_PSRC_BIT] ? cfg[MPOFU_CFG_PVAL_BIT] : gen_p;
        wire src_n = cfg[MPOFU_CFG_NSRC_BIT] ? cfg[MPOFU_CFG_NVAL_BIT] : gen_n;
        wire sw_p = cfg[MPOFU_CFG_SWAP_BIT] ? src_n : src_p;
        wire sw_n = cfg[MPOFU_CFG_SWAP_BIT] ? src_p : src_n;
        wire pol_p = sw_p ^ cfg[MPOFU_CFG_PPOL_BIT];
        wire pol_n = sw_n ^ cfg[MPOFU_CFG_NPOL_BIT];
        // default levels bypass swap and polarity so a fault parks the bridge predictably
        assign p_next[ch] = oe_reg ? pol_p : default_level_reg[2*ch];
        assign n_next[ch] = oe_reg ? pol_n : default_level_reg[2*ch+1];
        assign shoot_through[ch] = sw_p & sw_n;
    end

    wire [5:0] flag_set = {fault_input_one, fault_input_zero, shoot_through};
    wire [5:0] auto_mask = auto_clear ? 6'h30 : 6'h00;
    wire [5:0] flags_next = (fault_flags_reg & ~flag_w1c & ~auto_mask) | flag_set;
    wire fault_hit = fault_input_one | fault_input_zero;

    // ****************************************
    // register update
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            fault_flags_reg <= MPOFU_FLAGS_RESET;
            dma_enable_reg <= MPOFU_DMA_RESET;
            push_pull_reg <= MPOFU_PP_RESET;
            pair_a_reg <= MPOFU_PAIR_RESET;
            pair_b_reg <= MPOFU_PAIR_RESET;
            schedule_reg <= MPOFU_SCHED_RESET;
            default_level_reg <= MPOFU_DEFAULT_RESET;
            protect_key_reg <= MPOFU_KEY_RESET;
        end
        else
        begin
            fault_flags_reg <= flags_next;
            if (hit_dma)
                dma_enable_reg <= w_dma[MPOFU_DMA_W-1:0];
            if (hit_pp)
                push_pull_reg <= w_pp[MPOFU_PP_W-1:0];
            if (hit_pair_a)
                pair_a_reg <= w_pair_a[MPOFU_PAIR_W-1:0];
            if (hit_pair_b)
                pair_b_reg <= w_pair_b[MPOFU_PAIR_W-1:0];
            if (hit_sched)
                schedule_reg <= w_sched[MPOFU_SCHED_W-1:0];
            if (hit_out)
                default_level_reg <= w_out[MPOFU_DEFAULT_LSB +: 8];
            if (hit_protect)
                protect_key_reg <= w_key[MPOFU_KEY_W-1:0];
        end
    end

    // ****************************************
    // output enable, scheduling and pins
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            oe_reg <= 1'b0;
            upd_cnt_reg <= 4'h0;
            prev_cnt_reg <= '0;
            pp_phase_reg <= 1'b0;
            shadow_load_reg <= 1'b0;
            p_out_reg <= 4'h0;
            n_out_reg <= 4'h0;
            zc_req_reg <= 1'b0;
            st_req_reg <= 1'b0;
            adc_req_reg <= 4'h0;
        end
        else
        begin
            // a fault in the same cycle as a restore keeps the bridge off
            if (fault_hit)
                oe_reg <= 1'b0;
            else if (auto_clear)
                oe_reg <= 1'b1;
            else if (hit_out & s_axi_wstrb[0])
                oe_reg <= s_axi_wdata[MPOFU_OE_BIT];
            if (auto_load)
                upd_cnt_reg <= 4'h0;
            else if (sched_event)
                upd_cnt_reg <= upd_cnt_reg + 4'h1;
            prev_cnt_reg <= counter_value;
            if (pp_toggle)
                pp_phase_reg <= ~pp_phase_reg;
            shadow_load_reg <= auto_load | manual_load;
            p_out_reg <= p_next;
            n_out_reg <= n_next;
            zc_req_reg <= zero_event & dma_enable_reg[MPOFU_ZC_DMA_BIT];
            st_req_reg <= start_event & dma_enable_reg[MPOFU_START_DMA_BIT];
            adc_req_reg <= adc_trigger_event & dma_enable_reg[3:0];
        end
    end

    assign pwm_p_out = p_out_reg;
    assign pwm_n_out = n_out_reg;
    assign shadow_load = shadow_load_reg;
    assign output_enable_signal = oe_reg;
    assign zero_cross_dma_req = zc_req_reg;
    assign start_event_dma_req = st_req_reg;
    assign adc_trigger_dma_req = adc_req_reg;

    // ****************************************
    // read mux and responses
    // ****************************************
    logic [31:0] rd_value;
    logic rd_mapped;

    always_comb
    begin
        rd_mapped = 1'b1;
        if (s_axi_araddr == MPOFU_ADDR_FAULT_FLAGS)
            rd_value = {26'h0, fault_flags_reg};
        else if (s_axi_araddr == MPOFU_ADDR_DMA_ENABLE)
            rd_value = {26'h0, dma_enable_reg};
        else if (s_axi_araddr == MPOFU_ADDR_PUSH_PULL)
            rd_value = {28'h0, push_pull_reg};
        else if (s_axi_araddr == MPOFU_ADDR_PAIR_A)
            rd_value = {16'h0, pair_a_reg};
        else if (s_axi_araddr == MPOFU_ADDR_PAIR_B)
            rd_value = {16'h0, pair_b_reg};
        else if (s_axi_araddr == MPOFU_ADDR_SCHEDULE)
            rd_value = {25'h0, schedule_reg};
        else if (s_axi_araddr == MPOFU_ADDR_OUT_CTRL)
            rd_value = {16'h0, default_level_reg, 7'h00, oe_reg};
        else if (s_axi_araddr == MPOFU_ADDR_MANUAL_LOAD)
            rd_value = 32'h00000000;
        else if (s_axi_araddr == MPOFU_ADDR_PROTECT)
            rd_value = {16'h0, protect_key_reg};
        else
        begin
            rd_value = 32'h00000000;
            rd_mapped = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= MPOFU_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= MPOFU_RESP_OKAY;
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            if (wr_fire)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_mapped ? MPOFU_RESP_OKAY : MPOFU_RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_reg <= 1'b0;
            if (rd_fire)
            begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_value;
                rresp_reg <= rd_mapped ? MPOFU_RESP_OKAY : MPOFU_RESP_SLVERR;
            end
            else if (s_axi_rready)
                rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
endmodule : mpofu_top
`default_nettype wire
